// *** verification/mgmt_bus_master.sv ***
`timescale 1ns/1ps
module mgmt_bus_master
   import kr_phy_mgmt_pkg::*;
(
   // clock
   input  wire logic              clock_i,
   // answer from the slave
   input  wire logic              mgmt_waitrequest_i,
   input  wire logic [DATA_W-1:0] mgmt_readdata_i,
   // request to the slave
   output logic      [ADDR_W-1:0] mgmt_addr_o,
   output logic      [DATA_W-1:0] mgmt_writedata_o,
   output logic                   mgmt_write_o,
   output logic                   mgmt_read_o
);
   // ==========================================================
   // idle bus
   initial begin
      mgmt_addr_o      = 8'h5a;
      mgmt_writedata_o = 32'ha5a5_5a5a;
      mgmt_write_o     = 1'b0;
      mgmt_read_o      = 1'b0;
   end

   // ==========================================================
   // one access, request held until wait low is sampled
   task automatic access(input logic is_write, input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] wdata,
                         output logic [DATA_W-1:0] rdata, output int edges);
      bit done;
      done  = 1'b0;
      edges = 0;
      rdata = '0;
      @(posedge clock_i);
      mgmt_addr_o      <= addr;
      mgmt_writedata_o <= wdata;
      mgmt_write_o     <= is_write;
      mgmt_read_o      <= !is_write;
      while (!done && edges < 20) begin
         @(posedge clock_i);
         edges++;
         if (mgmt_waitrequest_i === 1'b0) begin
            done  = 1'b1;
            rdata = mgmt_readdata_i;
         end
      end
      mgmt_write_o     <= 1'b0;
      mgmt_read_o      <= 1'b0;
      // released lines must not keep the last value
      mgmt_addr_o      <= ~addr;
      mgmt_writedata_o <= ~wdata;
   endtask
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`define CHECK(got, exp) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) begin \
         error_cnt++; \
         $display("BAD %0t got %h expected %h", $time, (got), (exp)); \
      end \
   end
module testbench
   import kr_phy_mgmt_pkg::*;
;
   // ==========================================================
   // signals
   localparam logic [DATA_W-1:0] CTL_MASK = (32'h1 << CTL_AN_TIMER_BIT) | (32'h1 << CTL_LF_TIMER_BIT)
      | (32'h7 << CTL_FORCE_LSB) | (32'h1 << CTL_FEC_ABIL_BIT) | (32'h1 << CTL_FEC_ERR_BIT)
      | (32'h1 << CTL_FEC_REQ_BIT);
   localparam logic [DATA_W-1:0] ST_L = 32'h1 << STS_LINK_READY_BIT;
   localparam logic [DATA_W-1:0] ST_A = 32'h1 << STS_AN_TIMEOUT_BIT;
   localparam logic [DATA_W-1:0] ST_T = 32'h1 << STS_LT_TIMEOUT_BIT;
   logic              clock_i;
   logic              reset_i;
   logic [ADDR_W-1:0] mgmt_addr_i;
   logic [DATA_W-1:0] mgmt_writedata_i;
   logic              mgmt_write_i;
   logic              mgmt_read_i;
   logic [DATA_W-1:0] mgmt_readdata_o;
   logic              mgmt_waitrequest_o;
   logic              link_ready_i;
   logic              negotiation_timeout_i;
   logic              negotiation_restart_i;
   logic              training_timeout_i;
   logic              seq_reset_o;
   logic [2:0]        force_mode_o;
   logic [4:0]        ctl_vec;
   logic              negotiation_timer_off_o;
   logic              link_fault_timer_off_o;
   logic              fec_ability_advertise_o;
   logic              fec_error_report_on_o;
   logic              fec_request_o;
   int                error_cnt = 0;
   int                n_tests   = 0;
   int                pulse_cnt = 0;

   assign ctl_vec = {fec_request_o, fec_error_report_on_o, fec_ability_advertise_o, link_fault_timer_off_o,
                     negotiation_timer_off_o};

   // ==========================================================
   // design and master
   kr_phy_mgmt_registers #(.FEC_ABILITY_AT_RESET(1'b0)) dut (.*);

   mgmt_bus_master bus_master (
      .clock_i            (clock_i),
      .mgmt_waitrequest_i (mgmt_waitrequest_o),
      .mgmt_readdata_i    (mgmt_readdata_o),
      .mgmt_addr_o        (mgmt_addr_i),
      .mgmt_writedata_o   (mgmt_writedata_i),
      .mgmt_write_o       (mgmt_write_i),
      .mgmt_read_o        (mgmt_read_i)
   );

   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   always @(posedge clock_i) begin
      if (seq_reset_o === 1'b1) begin
         pulse_cnt <= pulse_cnt + 1;
      end
   end

   // ==========================================================
   // helpers
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] r);
      int edges;
      bus_master.access(w, a, d, r, edges);
      `CHECK(edges, 2)
      if (edges >= 20) begin
         complete_run();
      end
   endtask

   function automatic logic [4:0] ctl_exp(input logic [DATA_W-1:0] w);
      return {w[CTL_FEC_REQ_BIT], w[CTL_FEC_ERR_BIT], w[CTL_FEC_ABIL_BIT], w[CTL_LF_TIMER_BIT],
              w[CTL_AN_TIMER_BIT]};
   endfunction

   task automatic check_idle();
      `CHECK(mgmt_waitrequest_o, 1'b1)
      `CHECK(mgmt_readdata_o, READ_RESET_VALUE)
      `CHECK(ctl_vec, 5'h00)
      `CHECK(force_mode_o, FORCE_RESET_VALUE)
      `CHECK(seq_reset_o, 1'b0)
   endtask

   // ==========================================================
   // scenarios
   task automatic test_control();
      logic [DATA_W-1:0] pats [6] = '{32'h1 << CTL_AN_TIMER_BIT, 32'h1 << CTL_LF_TIMER_BIT,
         32'h1 << CTL_FEC_ABIL_BIT, 32'h1 << CTL_FEC_ERR_BIT, 32'h1 << CTL_FEC_REQ_BIT, 32'hffff_fffe};
      logic [DATA_W-1:0] r;
      int                p0;
      p0 = pulse_cnt;
      bus(1'b0, SEQ_CONTROL_ADDR, 32'h0, r);
      `CHECK(r, 32'h0)
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, SEQ_CONTROL_ADDR, pats[i], r);
         @(negedge clock_i);
         `CHECK(ctl_vec, ctl_exp(pats[i]))
         `CHECK(force_mode_o, FORCE_NONE)
         bus(1'b0, SEQ_CONTROL_ADDR, 32'h0, r);
         `CHECK(r, pats[i] & CTL_MASK)
      end
      `CHECK(pulse_cnt, p0)
   endtask

   task automatic test_force();
      logic [2:0]        codes [5] = '{FORCE_NONE, FORCE_GIGE, FORCE_10G, FORCE_RSV0, FORCE_RSV1};
      logic [2:0]        exps [5]  = '{FORCE_NONE, FORCE_GIGE, FORCE_10G, FORCE_NONE, FORCE_NONE};
      logic [DATA_W-1:0] r;
      logic [DATA_W-1:0] v;
      logic [2:0]        held;
      int                p0;
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, SEQ_CONTROL_ADDR, 32'h0, r);
         v    = (r & ~(32'h7 << CTL_FORCE_LSB)) | ({29'h0, codes[i]} << CTL_FORCE_LSB);
         held = force_mode_o;
         p0   = pulse_cnt;
         bus(1'b1, SEQ_CONTROL_ADDR, v, r);
         @(negedge clock_i);
         `CHECK(force_mode_o, held)
         v = (v ^ (32'h1 << CTL_FEC_REQ_BIT)) | 32'h1;
         bus(1'b1, SEQ_CONTROL_ADDR, v, r);
         repeat (2) @(negedge clock_i);
         `CHECK(pulse_cnt - p0, 1)
         `CHECK(force_mode_o, exps[i])
         `CHECK(fec_request_o, v[CTL_FEC_REQ_BIT])
         bus(1'b0, SEQ_CONTROL_ADDR, 32'h0, r);
         `CHECK(r, v & CTL_MASK)
      end
   endtask

   task automatic test_status();
      logic [DATA_W-1:0] r;
      link_ready_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      bus(1'b0, SEQ_STATUS_ADDR, 32'h0, r);
      `CHECK(r, ST_L)
      negotiation_timeout_i <= 1'b1;
      @(posedge clock_i);
      negotiation_timeout_i <= 1'b0;
      bus(1'b0, SEQ_STATUS_ADDR, 32'h0, r);
      bus(1'b0, SEQ_STATUS_ADDR, 32'h0, r);
      `CHECK(r, ST_L | ST_A)
      training_timeout_i <= 1'b1;
      @(posedge clock_i);
      training_timeout_i    <= 1'b0;
      negotiation_restart_i <= 1'b1;
      @(posedge clock_i);
      negotiation_restart_i <= 1'b0;
      bus(1'b0, SEQ_STATUS_ADDR, 32'h0, r);
      `CHECK(r, ST_L | ST_T)
      negotiation_timeout_i <= 1'b1;
      negotiation_restart_i <= 1'b1;
      @(posedge clock_i);
      negotiation_timeout_i <= 1'b0;
      negotiation_restart_i <= 1'b0;
      bus(1'b0, SEQ_STATUS_ADDR, 32'h0, r);
      `CHECK(r, ST_L | ST_A | ST_T)
      negotiation_restart_i <= 1'b1;
      @(posedge clock_i);
      negotiation_restart_i <= 1'b0;
      link_ready_i          <= 1'b0;
      bus(1'b0, SEQ_CONTROL_ADDR, 32'h0, r);
      bus(1'b1, SEQ_CONTROL_ADDR, r | 32'h1, r);
      repeat (2) @(posedge clock_i);
      bus(1'b0, SEQ_STATUS_ADDR, 32'h0, r);
      `CHECK(r, 32'h0)
   endtask

   task automatic test_bus();
      logic [ADDR_W-1:0] addrs [3] = '{8'h00, 8'hb2, 8'hff};
      logic [DATA_W-1:0] r;
      for (int i = 0; i < 3; i++) begin
         bus(1'b0, SEQ_CONTROL_ADDR, 32'h0, r);
         bus(1'b0, addrs[i], 32'h0, r);
         `CHECK(r, 32'h0)
      end
      bus(1'b1, SEQ_CONTROL_ADDR, 32'hffff_fffe, r);
      @(posedge clock_i);
      reset_i <= 1'b1;
      repeat (2) @(negedge clock_i);
      check_idle();
      @(posedge clock_i);
      reset_i <= 1'b0;
      bus(1'b0, SEQ_CONTROL_ADDR, 32'h0, r);
      `CHECK(r, 32'h0)
   endtask

   // ==========================================================
   // main sequence
   initial begin
      reset_i               = 1'b1;
      link_ready_i          = 1'b0;
      negotiation_timeout_i = 1'b0;
      negotiation_restart_i = 1'b0;
      training_timeout_i    = 1'b0;
      repeat (5) @(negedge clock_i);
      check_idle();
      repeat (5) @(posedge clock_i);
      reset_i <= 1'b0;
      test_control();
      test_force();
      test_status();
      test_bus();
      complete_run();
   end
endmodule

// *** verilog/kr_phy_mgmt_pkg.sv ***
package kr_phy_mgmt_pkg;

   // ==========================================================
   // bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // ==========================================================
   // register word addresses
   localparam logic [ADDR_W-1:0] SEQ_CONTROL_ADDR = 8'hb0;
   localparam logic [ADDR_W-1:0] SEQ_STATUS_ADDR  = 8'hb1;

   // ==========================================================
   // control word field positions
   localparam int CTL_SEQ_RESET_BIT  = 0;
   localparam int CTL_AN_TIMER_BIT   = 1;
   localparam int CTL_LF_TIMER_BIT   = 2;
   localparam int CTL_FORCE_LSB      = 4;
   localparam int CTL_FORCE_MSB      = 6;
   localparam int CTL_FEC_ABIL_BIT   = 16;
   localparam int CTL_FEC_ERR_BIT    = 17;
   localparam int CTL_FEC_REQ_BIT    = 18;

   // ==========================================================
   // status word field positions
   localparam int STS_LINK_READY_BIT = 0;
   localparam int STS_AN_TIMEOUT_BIT = 1;
   localparam int STS_LT_TIMEOUT_BIT = 2;
   localparam int NUM_FLAGS          = 2;

   // ==========================================================
   // forced protocol codes
   localparam logic [2:0] FORCE_NONE = 3'h0;
   localparam logic [2:0] FORCE_RSV0 = 3'h2;
   localparam logic [2:0] FORCE_GIGE = 3'h3;
   localparam logic [2:0] FORCE_10G  = 3'h5;
   localparam logic [2:0] FORCE_RSV1 = 3'h7;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic              read;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } mgmt_req_t;

   typedef struct packed {
      logic       fec_request;
      logic       fec_error_report_on;
      logic       fec_ability_advertise;
      logic [2:0] force_mode;
      logic       link_fault_timer_off;
      logic       negotiation_timer_off;
   } seq_ctrl_t;

   // ==========================================================
   // values after reset
   localparam seq_ctrl_t CTRL_RESET_VALUE = '0;
   localparam logic [DATA_W-1:0] READ_RESET_VALUE = 32'h0000_0000;
   localparam logic [2:0] FORCE_RESET_VALUE = FORCE_NONE;

endpackage

// *** verilog/kr_phy_mgmt_registers.sv ***
`timescale 1ns/1ps
// Functional notes
// - management reset is active high, level sensitive; logic held in reset meanwhile
// - all registers in one space: 8-bit word address, 32-bit data both ways
// - write and read strobes are active high
// - wait-request stays high until the presented request can complete
// - every field resets to zero unless it names another default
// - writing 1 to control bit 0 pulses a sequencer reset; bit self-clears
// - control bit 1 set turns the negotiation timer off
// - control bit 2 set turns the link-fault timer off
// - forced protocol bits 6:4 reach the sequencer only on a sequencer reset
// - force codes: 000 none, 011 gigabit, 101 ten gigabit, 010/111 reserved
// - control bit 16 advertises FEC ability; may reset to 1 by build option
// - control bit 17 lets FEC decode errors reach the 10G PCS
// - control bit 18 requests FEC from the link partner
// - status bit 0 reads 1 while the link is ready
// - status bit 1 latches negotiation timeout until negotiation restarts
// - status bit 2 reads 1 after a link-training timeout
module kr_phy_mgmt_registers
   import kr_phy_mgmt_pkg::*;
#(
   parameter logic FEC_ABILITY_AT_RESET = 1'b0
)
(
   // clock and reset
   input  wire logic              clock_i,
   input  wire logic              reset_i,
   // management port
   input  wire logic [ADDR_W-1:0] mgmt_addr_i,
   input  wire logic [DATA_W-1:0] mgmt_writedata_i,
   input  wire logic              mgmt_write_i,
   input  wire logic              mgmt_read_i,
   output logic      [DATA_W-1:0] mgmt_readdata_o,
   output logic                   mgmt_waitrequest_o,
   // sequencer status
   input  wire logic              link_ready_i,
   input  wire logic              negotiation_timeout_i,
   input  wire logic              negotiation_restart_i,
   input  wire logic              training_timeout_i,
   // sequencer control
   output logic                   seq_reset_o,
   output logic      [2:0]        force_mode_o,
   output logic                   negotiation_timer_off_o,
   output logic                   link_fault_timer_off_o,
   output logic                   fec_ability_advertise_o,
   output logic                   fec_error_report_on_o,
   output logic                   fec_request_o
);

   // ==========================================================
   // declarations
   mgmt_req_t         req;
   logic              take;
   logic              take_write;
   logic              take_read;
   logic              hit_control;
   logic              hit_status;
   seq_ctrl_t         ctrl;
   seq_ctrl_t         next_ctrl;
   logic              link_ready;
   logic [NUM_FLAGS-1:0] flag_set;
   logic [NUM_FLAGS-1:0] flag_clear;
   logic [NUM_FLAGS-1:0] flag;
   logic              negotiation_timeout_flag;
   logic              training_timeout_flag;
   logic [DATA_W-1:0] next_readdata;

   // ==========================================================
   // reserved force codes fall back to no forcing
   function automatic logic [2:0] legal_force(input logic [2:0] code);
      logic [2:0] result;
      result = code;
      if ((code == FORCE_RSV0) || (code == FORCE_RSV1)) begin
         result = FORCE_NONE;
      end
      return result;
   endfunction

   // ==========================================================
   // address decode
   function automatic logic addr_is(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] target);
      return addr == target;
   endfunction

   // ==========================================================
   // request carrier
   always_comb begin
      req.read  = mgmt_read_i;
      req.write = mgmt_write_i;
      req.addr  = mgmt_addr_i;
      req.wdata = mgmt_writedata_i;
   end

   // ==========================================================
   // handshake
   mgmt_slave_port u_port (
      .clock_i       (clock_i),
      .reset_i       (reset_i),
      .req_i         (req),
      .take_o        (take),
      .waitrequest_o (mgmt_waitrequest_o)
   );

   assign hit_control = addr_is(req.addr, SEQ_CONTROL_ADDR);
   assign hit_status  = addr_is(req.addr, SEQ_STATUS_ADDR);
   assign take_write  = take && req.write;
   assign take_read   = take && req.read && !req.write;

   // ==========================================================
   // control word
   always_comb begin
      next_ctrl = ctrl;
      if (take_write && hit_control) begin
         next_ctrl.negotiation_timer_off = req.wdata[CTL_AN_TIMER_BIT];
         next_ctrl.link_fault_timer_off  = req.wdata[CTL_LF_TIMER_BIT];
         next_ctrl.force_mode            = req.wdata[CTL_FORCE_MSB:CTL_FORCE_LSB];
         next_ctrl.fec_ability_advertise = req.wdata[CTL_FEC_ABIL_BIT];
         next_ctrl.fec_error_report_on   = req.wdata[CTL_FEC_ERR_BIT];
         next_ctrl.fec_request           = req.wdata[CTL_FEC_REQ_BIT];
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         ctrl <= CTRL_RESET_VALUE;
         ctrl.fec_ability_advertise <= FEC_ABILITY_AT_RESET;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   assign negotiation_timer_off_o = ctrl.negotiation_timer_off;
   assign link_fault_timer_off_o  = ctrl.link_fault_timer_off;
   assign fec_ability_advertise_o = ctrl.fec_ability_advertise;
   assign fec_error_report_on_o   = ctrl.fec_error_report_on;
   assign fec_request_o           = ctrl.fec_request;

   // ==========================================================
   // sequencer reset pulse, self-clearing
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         seq_reset_o <= 1'b0;
      end else begin
         seq_reset_o <= take_write && hit_control && req.wdata[CTL_SEQ_RESET_BIT];
      end
   end

   // ==========================================================
   // forced protocol applied only with a sequencer reset
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         force_mode_o <= FORCE_RESET_VALUE;
      end else if (take_write && hit_control && req.wdata[CTL_SEQ_RESET_BIT]) begin
         force_mode_o <= legal_force(req.wdata[CTL_FORCE_MSB:CTL_FORCE_LSB]);
      end
   end

   // ==========================================================
   // status sources
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         link_ready <= 1'b0;
      end else begin
         link_ready <= link_ready_i;
      end
   end

   assign flag_set[0]   = negotiation_timeout_i;
   assign flag_clear[0] = negotiation_restart_i;
   assign flag_set[1]   = training_timeout_i;
   assign flag_clear[1] = seq_reset_o;

   generate
      for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
         sticky_flag u_flag (
            .clock_i (clock_i),
            .reset_i (reset_i),
            .set_i   (flag_set[i]),
            .clear_i (flag_clear[i]),
            .flag_o  (flag[i])
         );
      end
   endgenerate

   assign negotiation_timeout_flag = flag[0];
   assign training_timeout_flag    = flag[1];

   // ==========================================================
   // read data, captured when a read is taken
   always_comb begin
      next_readdata = READ_RESET_VALUE;
      if (hit_control) begin
         next_readdata[CTL_AN_TIMER_BIT] = ctrl.negotiation_timer_off;
         next_readdata[CTL_LF_TIMER_BIT] = ctrl.link_fault_timer_off;
         next_readdata[CTL_FORCE_MSB:CTL_FORCE_LSB] = ctrl.force_mode;
         next_readdata[CTL_FEC_ABIL_BIT] = ctrl.fec_ability_advertise;
         next_readdata[CTL_FEC_ERR_BIT]  = ctrl.fec_error_report_on;
         next_readdata[CTL_FEC_REQ_BIT]  = ctrl.fec_request;
      end else if (hit_status) begin
         next_readdata[STS_LINK_READY_BIT] = link_ready;
         next_readdata[STS_AN_TIMEOUT_BIT] = negotiation_timeout_flag;
         next_readdata[STS_LT_TIMEOUT_BIT] = training_timeout_flag;
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         mgmt_readdata_o <= READ_RESET_VALUE;
      end else if (take_read) begin
         mgmt_readdata_o <= next_readdata;
      end
   end

   // ==========================================================
   // checks
   property p_reset_release;
      @(posedge clock_i)
      $fell(reset_i) |-> (mgmt_waitrequest_o && !seq_reset_o && force_mode_o == FORCE_NONE);
   endproperty
   a_reset_release: assert property (p_reset_release)
      else $error("outputs not idle at reset release");

   property p_reset_defaults;
      @(posedge clock_i)
      $fell(reset_i) |-> (!negotiation_timer_off_o && !link_fault_timer_off_o && !fec_request_o
                          && fec_ability_advertise_o == FEC_ABILITY_AT_RESET);
   endproperty
   a_reset_defaults: assert property (p_reset_defaults)
      else $error("control fields wrong after reset");

   property p_wait_window;
      @(posedge clock_i) disable iff (reset_i)
      take |=> !mgmt_waitrequest_o ##1 mgmt_waitrequest_o;
   endproperty
   a_wait_window: assert property (p_wait_window)
      else $error("wait-request not low for one cycle after a take");

   property p_wait_needs_take;
      @(posedge clock_i) disable iff (reset_i)
      !mgmt_waitrequest_o |-> $past(mgmt_read_i || mgmt_write_i);
   endproperty
   a_wait_needs_take: assert property (p_wait_needs_take)
      else $error("wait-request low without a request");

   property p_ctrl_write;
      @(posedge clock_i) disable iff (reset_i)
      (take_write && hit_control) |=>
         (negotiation_timer_off_o == $past(mgmt_writedata_i[CTL_AN_TIMER_BIT])
          && link_fault_timer_off_o == $past(mgmt_writedata_i[CTL_LF_TIMER_BIT])
          && fec_request_o == $past(mgmt_writedata_i[CTL_FEC_REQ_BIT]));
   endproperty
   a_ctrl_write: assert property (p_ctrl_write)
      else $error("control write not stored");

   property p_seq_reset_pulse;
      @(posedge clock_i) disable iff (reset_i)
      (take_write && hit_control && mgmt_writedata_i[CTL_SEQ_RESET_BIT])
         |=> seq_reset_o ##1 !seq_reset_o;
   endproperty
   a_seq_reset_pulse: assert property (p_seq_reset_pulse)
      else $error("sequencer reset not a single pulse");

   property p_force_only_on_reset;
      @(posedge clock_i) disable iff (reset_i)
      $changed(force_mode_o) |-> seq_reset_o;
   endproperty
   a_force_only_on_reset: assert property (p_force_only_on_reset)
      else $error("forced protocol changed without sequencer reset");

   property p_force_legal;
      @(posedge clock_i) disable iff (reset_i)
      seq_reset_o |-> (force_mode_o != FORCE_RSV0 && force_mode_o != FORCE_RSV1);
   endproperty
   a_force_legal: assert property (p_force_legal)
      else $error("reserved force code applied");

   property p_link_ready_read;
      @(posedge clock_i) disable iff (reset_i)
      (take_read && hit_status) |=>
         mgmt_readdata_o[STS_LINK_READY_BIT] == $past(link_ready_i, 2);
   endproperty
   a_link_ready_read: assert property (p_link_ready_read)
      else $error("link ready bit misread");

   property p_an_timeout_latch;
      @(posedge clock_i) disable iff (reset_i)
      negotiation_timeout_i |=> negotiation_timeout_flag;
   endproperty
   a_an_timeout_latch: assert property (p_an_timeout_latch)
      else $error("negotiation timeout not latched");

   property p_an_timeout_hold;
      @(posedge clock_i) disable iff (reset_i)
      (negotiation_timeout_flag && !negotiation_restart_i) |=> negotiation_timeout_flag;
   endproperty
   a_an_timeout_hold: assert property (p_an_timeout_hold)
      else $error("negotiation timeout dropped without restart");

   property p_lt_timeout;
      @(posedge clock_i) disable iff (reset_i)
      training_timeout_i |=> training_timeout_flag;
   endproperty
   a_lt_timeout: assert property (p_lt_timeout)
      else $error("training timeout not reported");

   property p_unmapped_zero;
      @(posedge clock_i) disable iff (reset_i)
      (take_read && !hit_control && !hit_status) |=> (mgmt_readdata_o == '0) && !mgmt_waitrequest_o;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero)
      else $error("unmapped read not zero");

   property p_reserved_zero;
      @(posedge clock_i) disable iff (reset_i)
      (take_read && hit_status) |=> (mgmt_readdata_o[DATA_W-1:STS_LT_TIMEOUT_BIT+1] == '0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("status reserved bits not zero");

   property p_fec_write;
      @(posedge clock_i) disable iff (reset_i)
      (take_write && hit_control) |=>
         (fec_error_report_on_o == $past(mgmt_writedata_i[CTL_FEC_ERR_BIT])
          && fec_ability_advertise_o == $past(mgmt_writedata_i[CTL_FEC_ABIL_BIT]));
   endproperty
   a_fec_write: assert property (p_fec_write)
      else $error("FEC control bits not stored");

   property p_wait_idle;
      @(posedge clock_i) disable iff (reset_i)
      (mgmt_waitrequest_o && !mgmt_read_i && !mgmt_write_i) |=> mgmt_waitrequest_o;
   endproperty
   a_wait_idle: assert property (p_wait_idle)
      else $error("wait-request dropped with no request");

   property p_restart_clears;
      @(posedge clock_i) disable iff (reset_i)
      (negotiation_restart_i && !negotiation_timeout_i) |=> !negotiation_timeout_flag;
   endproperty
   a_restart_clears: assert property (p_restart_clears)
      else $error("negotiation timeout not cleared by restart");

endmodule

// *** verilog/mgmt_slave_port.sv ***
`timescale 1ns/1ps
module mgmt_slave_port
   import kr_phy_mgmt_pkg::*;
(
   // clock and reset
   input  wire logic      clock_i,
   input  wire logic      reset_i,
   // request from master
   input  wire mgmt_req_t req_i,
   // handshake
   output logic           take_o,
   output logic           waitrequest_o
);

   // ==========================================================
   // one-hot handshake states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_DONE = 2'b10
   } port_state_t;

   port_state_t state;
   port_state_t next_state;

   // ==========================================================
   // request taken only from idle
   assign take_o = (state == ST_IDLE) && (req_i.read || req_i.write);

   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (take_o) begin
               next_state = ST_DONE;
            end
         end
         ST_DONE: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================
   // wait low for exactly the cycle after a take
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         waitrequest_o <= 1'b1;
      end else begin
         waitrequest_o <= !take_o;
      end
   end

endmodule

// *** verilog/sticky_flag.sv ***
`timescale 1ns/1ps
module sticky_flag
   import kr_phy_mgmt_pkg::*;
(
   // clock and reset
   input  wire logic clock_i,
   input  wire logic reset_i,
   // event and clear
   input  wire logic set_i,
   input  wire logic clear_i,
   // latched state
   output logic      flag_o
);

   // ==========================================================
   // set wins over a same-cycle clear
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         flag_o <= 1'b0;
      end else if (set_i) begin
         flag_o <= 1'b1;
      end else if (clear_i) begin
         flag_o <= 1'b0;
      end
   end

endmodule
